// ===== logic/sacc_regs.svh
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH
// apb register byte addresses
`define SACC_CTRL_ADDR 12'h000
`define SACC_TIMING_ADDR 12'h004
`define SACC_STATUS_ADDR 12'h008
`define SACC_RESULT_ADDR 12'h00C
`define SACC_IRQ_STAT_ADDR 12'h010
`define SACC_IRQ_MASK_ADDR 12'h014
// ctrl fields
`define SACC_CTRL_RES_LSB 0
`define SACC_CTRL_PWR_BIT 2
`define SACC_CTRL_NOCAL_BIT 3
`define SACC_CTRL_REF_BIT 4
`define SACC_CTRL_CHAN_LSB 8
`define SACC_CTRL_GO_BIT 16
`define SACC_CTRL_RESET 32'h0000_0000
// timing fields
`define SACC_TIM_DIV_LSB 0
`define SACC_TIM_ACQ_LSB 8
`define SACC_TIMING_RESET 32'h0000_0000
// status bits
`define SACC_ST_BUSY_BIT 0
`define SACC_ST_SAMPLE_BIT 1
`define SACC_ST_VALID_BIT 2
`define SACC_ST_CAL_BIT 3
`define SACC_ST_PWR_BIT 4
// irq bits: 0 done, 1 power-up calibration done
`define SACC_IRQ_WIDTH 2
// timing counts
`define SACC_DIV_MULT 4
`define SACC_SAMPLE_BASE 2
`define SACC_POSTCAL_CYC 2
`define SACC_PWRUP_CAL_CYC 3840
`endif

// ===== logic/sacc_pkg.sv
package sacc_pkg;
	typedef enum logic [2:0] {
		SACC_PWRUP = 3'b000,
		SACC_IDLE = 3'b001,
		SACC_SAMPLE = 3'b010,
		SACC_DISTRIB = 3'b011,
		SACC_POSTCAL = 3'b100
	} sacc_state_e;
	typedef enum logic [1:0] {
		SACC_RES_10 = 2'b00,
		SACC_RES_12 = 2'b01,
		SACC_RES_8 = 2'b10,
		SACC_RES_UNUSED = 2'b11
	} sacc_res_e;
endpackage

// ===== logic/sacc_clkdiv.sv
`timescale 1ns/100ps
// conversion clock tick: one pulse every 4*(1+div) host clocks
module sacc_clkdiv #(
	parameter int DIV_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic restart,
	input wire logic [DIV_W-1:0] div_value,
	output logic tick
);
	logic [DIV_W+1:0] cnt_q;
	wire [DIV_W+1:0] period_m1 = {div_value, 2'b11};
	wire at_end = (cnt_q >= period_m1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (clk_en) begin
			tick <= at_end && !restart;
			cnt_q <= (at_end || restart) ? '0 : cnt_q + 1'b1;
		end
	end
endmodule

// ===== logic/sacc_ctrl.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "sacc_regs.svh"
module sacc_ctrl
	import sacc_pkg::*;
#(
	parameter int PWRUP_CAL_CYC = `SACC_PWRUP_CAL_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [11:0] sar_value,
	output logic [11:0] result,
	output logic [4:0] channel_select,
	output logic busy,
	output logic sampling,
	output logic value_ready,
	output logic calibrating,
	output logic comparator_on,
	output logic sample_hold,
	output logic reference_select_pin,
	output logic irq
);
	import sacc_pkg::*;

	function automatic logic [3:0] res_bits(input logic [1:0] code);
		unique case (code)
			SACC_RES_10: res_bits = 4'd10;
			SACC_RES_8: res_bits = 4'd8;
			default: res_bits = 4'd12;
		endcase
	endfunction

	function automatic logic [11:0] justify(input logic [11:0] v, input logic [1:0] code);
		unique case (code)
			SACC_RES_8: justify = {v[11:4], 4'h0};
			SACC_RES_10: justify = {v[11:2], 2'b00};
			default: justify = v;
		endcase
	endfunction

	logic [31:0] ctrl_q;
	logic [31:0] timing_q;
	logic [`SACC_IRQ_WIDTH-1:0] irq_stat_q;
	logic [`SACC_IRQ_WIDTH-1:0] irq_mask_q;
	sacc_state_e state_q;
	logic [11:0] cnt_q;
	logic [1:0] res_q;
	logic nocal_q;
	logic pwr_keep_q;
	logic [7:0] div_q;
	logic [7:0] acq_q;
	logic go_q;

	// apb decode
	wire apb_acc = psel && penable;
	wire apb_wr = apb_acc && pwrite;
	wire hit_ctrl = paddr == `SACC_CTRL_ADDR;
	wire hit_tim = paddr == `SACC_TIMING_ADDR;
	wire hit_stat = paddr == `SACC_STATUS_ADDR;
	wire hit_res = paddr == `SACC_RESULT_ADDR;
	wire hit_is = paddr == `SACC_IRQ_STAT_ADDR;
	wire hit_im = paddr == `SACC_IRQ_MASK_ADDR;
	wire hit_any = hit_ctrl || hit_tim || hit_stat || hit_res || hit_is || hit_im;
	// write of go bit is the one-cycle start pulse
	wire start = apb_wr && hit_ctrl && pwdata[`SACC_CTRL_GO_BIT];

	wire [1:0] res_in = ctrl_q[`SACC_CTRL_RES_LSB +: 2];
	wire [7:0] div_in = timing_q[`SACC_TIM_DIV_LSB +: 8];
	wire [7:0] acq_in = timing_q[`SACC_TIM_ACQ_LSB +: 8];

	// divider uses captured value while converting
	wire in_conv = (state_q == SACC_SAMPLE) || (state_q == SACC_DISTRIB)
		|| (state_q == SACC_POSTCAL);
	wire [7:0] div_use = in_conv ? div_q : div_in;
	wire tick;

	sacc_clkdiv #(.DIV_W(8)) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.restart(go_q),
		.div_value(div_use),
		.tick(tick)
	);

	wire [11:0] sample_len = 12'(`SACC_SAMPLE_BASE) + {4'h0, acq_q};
	wire [11:0] dist_len = {8'h0, res_bits(res_q)};
	wire [11:0] cnt_inc = cnt_q + 12'd1;
	wire conv_done = tick && ((state_q == SACC_POSTCAL && cnt_inc == 12'(`SACC_POSTCAL_CYC))
		|| (state_q == SACC_DISTRIB && cnt_inc == dist_len && nocal_q));
	wire cal_done = tick && state_q == SACC_PWRUP && cnt_inc == 12'(PWRUP_CAL_CYC);
	wire [`SACC_IRQ_WIDTH-1:0] irq_ev = {cal_done, conv_done};

	wire [31:0] status_word = {27'h0, comparator_on, calibrating, value_ready, sampling, busy};
	wire [31:0] rd_mux = hit_ctrl ? {15'h0, 1'b0, ctrl_q[15:0]} :
		hit_tim ? timing_q :
		hit_stat ? status_word :
		hit_res ? {20'h0, result} :
		hit_is ? {30'h0, irq_stat_q} :
		hit_im ? {30'h0, irq_mask_q} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `SACC_CTRL_RESET;
			timing_q <= `SACC_TIMING_RESET;
			irq_mask_q <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit_any;
			if (psel && !penable && !pwrite)
				prdata <= rd_mux;
			if (apb_wr && hit_ctrl)
				ctrl_q <= {16'h0, pwdata[15:0]};
			if (apb_wr && hit_tim)
				timing_q <= {16'h0, pwdata[15:0]};
			if (apb_wr && hit_im)
				irq_mask_q <= pwdata[`SACC_IRQ_WIDTH-1:0];
		end
	end

	// sticky events; set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
			irq <= 1'b0;
		end else if (clk_en) begin
			irq_stat_q <= (irq_stat_q & ~((apb_wr && hit_is) ?
				pwdata[`SACC_IRQ_WIDTH-1:0] : '0)) | irq_ev;
			irq <= |((irq_stat_q | irq_ev) & irq_mask_q);
		end
	end

	// capture settings and start registered on the host clock edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_q <= 1'b0;
			res_q <= 2'b00;
			nocal_q <= 1'b0;
			pwr_keep_q <= 1'b0;
			div_q <= 8'h00;
			acq_q <= 8'h00;
			channel_select <= 5'h00;
		end else if (clk_en) begin
			go_q <= start;
			if (start) begin
				res_q <= pwdata[`SACC_CTRL_RES_LSB +: 2];
				nocal_q <= pwdata[`SACC_CTRL_NOCAL_BIT];
				pwr_keep_q <= pwdata[`SACC_CTRL_PWR_BIT];
				channel_select <= pwdata[`SACC_CTRL_CHAN_LSB +: 5];
				div_q <= div_in;
				acq_q <= acq_in;
			end
		end
	end

	// conversion sequencer; a new start aborts the running one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SACC_PWRUP;
			cnt_q <= 12'h000;
			busy <= 1'b0;
			sampling <= 1'b0;
			value_ready <= 1'b0;
			calibrating <= 1'b1;
			comparator_on <= 1'b1;
			sample_hold <= 1'b0;
			result <= 12'h000;
		end else if (clk_en) begin
			if (go_q) begin
				state_q <= SACC_SAMPLE;
				cnt_q <= 12'h000;
				busy <= 1'b1;
				sampling <= 1'b1;
				sample_hold <= 1'b1;
				value_ready <= 1'b0;
				comparator_on <= 1'b1;
			end else if (tick) begin
				unique case (state_q)
					SACC_PWRUP: begin
						cnt_q <= cnt_inc;
						if (cal_done) begin
							state_q <= SACC_IDLE;
							calibrating <= 1'b0;
							comparator_on <= 1'b0;
						end
					end
					SACC_IDLE: cnt_q <= 12'h000;
					SACC_SAMPLE: begin
						cnt_q <= cnt_inc;
						if (cnt_inc == sample_len) begin
							state_q <= SACC_DISTRIB;
							cnt_q <= 12'h000;
							sampling <= 1'b0;
							sample_hold <= 1'b0;
						end
					end
					SACC_DISTRIB: begin
						cnt_q <= cnt_inc;
						if (cnt_inc == dist_len) begin
							cnt_q <= 12'h000;
							state_q <= nocal_q ? SACC_IDLE : SACC_POSTCAL;
						end
					end
					SACC_POSTCAL: cnt_q <= cnt_inc;
					default: state_q <= SACC_IDLE;
				endcase
				if (conv_done) begin
					state_q <= SACC_IDLE;
					busy <= 1'b0;
					value_ready <= 1'b1;
					result <= justify(sar_value, res_q);
					comparator_on <= pwr_keep_q;
				end
			end
		end
	end

	// reference select follows the control bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			reference_select_pin <= 1'b0;
		else if (clk_en)
			reference_select_pin <= ctrl_q[`SACC_CTRL_REF_BIT];
	end
endmodule

// ===== verif/sacc_conv_model.sv
`timescale 1ns/100ps
// converter core: raw value tied to the selected channel
module sacc_conv_model (
	input wire logic [4:0] channel_select,
	output logic [11:0] sar_value
);
	assign sar_value = {channel_select, ~channel_select, 2'b11};
endmodule

// ===== verif/sacc_ctrl_asserts.sv
`timescale 1ns/100ps
module sacc_ctrl_asserts #(
	parameter int PWRUP_CAL_CYC = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busy,
	input wire logic sampling,
	input wire logic sample_hold,
	input wire logic value_ready,
	input wire logic [11:0] result,
	input wire logic [4:0] channel_select,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	busy_start_a: assert property ($rose(busy) |-> sampling && !value_ready)
		else $error("busy rose without sampling");
	samp_busy_a: assert property (sampling |-> busy)
		else $error("sampling without busy");
	samp_len_a: assert property ($rose(sampling) |-> sampling [*8])
		else $error("sample phase too short");
	hold_track_a: assert property (sample_hold == sampling)
		else $error("sample hold differs from sampling");
	samp_end_a: assert property ($fell(sampling) |-> busy)
		else $error("busy dropped with sampling");
	done_valid_a: assert property ($fell(busy) |-> value_ready)
		else $error("no valid at completion");
	valid_idle_a: assert property (value_ready |-> !busy && !sampling)
		else $error("valid while busy");
	result_hold_a: assert property ($past(value_ready) && value_ready |-> $stable(result))
		else $error("result moved while valid");
	chan_hold_a: assert property (busy && !sampling |-> $stable(channel_select))
		else $error("channel moved mid conversion");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("no ready in access cycle");
	cover property ($fell(busy));
	cover property (pslverr);
	cover property ($rose(irq));
endmodule

// ===== verif/tb.sv
`timescale 1ns/100ps
`include "sacc_regs.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, busy, sampling;
	logic value_ready, calibrating, comparator_on, reference_select_pin, irq;
	logic [11:0] paddr, sar_value, result, raw, exp_res;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] channel_select, ch;
	int error_cnt = 0;
	int n_compared = 0;
	int nb[4] = '{10, 12, 8, 12};
	int t, lo, cnt, k;
	sacc_ctrl #(.PWRUP_CAL_CYC(4)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sar_value(sar_value),
		.result(result), .channel_select(channel_select), .busy(busy), .sampling(sampling),
		.value_ready(value_ready), .calibrating(calibrating), .comparator_on(comparator_on),
		.sample_hold(), .reference_select_pin(reference_select_pin), .irq(irq));
	sacc_conv_model conv_i (.channel_select(channel_select), .sar_value(sar_value));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task conclude;
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			$display("MISMATCH %s exp %h got %h", n, e, s);
			error_cnt++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `SACC_TIMING_ADDR, 32'h0);
		chk("timing_rst", `SACC_TIMING_RESET, rd);
		k = 0;
		while (calibrating === 1'b1 && k < 400) begin
			@(posedge pclk);
			k++;
		end
		chk("cal_flag", 32'h0, calibrating);
		apb(1'b0, `SACC_IRQ_STAT_ADDR, 32'h0);
		chk("pwrup_cal", 32'h0000_0002, rd);
		apb(1'b1, `SACC_IRQ_STAT_ADDR, 32'h0000_0002);
		apb(1'b1, `SACC_IRQ_MASK_ADDR, 32'h0000_0001);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", 32'h0000_0001, {rd[30:0], er});
		for (int i = 0; i < 4; i++) begin
			ch = 5'(i * 9 + 3);
			apb(1'b1, `SACC_TIMING_ADDR, {16'h0, 8'(i), 8'(i + 1)});
			apb(1'b1, `SACC_CTRL_ADDR, {15'h0, 1'b1, 3'h0, ch, 3'h0, i[0], i[0], i[1], i[1:0]});
			repeat (2) @(posedge pclk);
			cnt = 0;
			k = 0;
			while (value_ready !== 1'b1 && k < 5000) begin
				@(posedge pclk);
				k++;
				if (busy === 1'b1)
					cnt++;
			end
			t = 4 * (2 + i);
			lo = t * (2 + i + nb[i] + (i[0] ? 0 : 2));
			chk("busy_len", 32'h1, cnt >= lo - t && cnt <= lo + t);
			raw = {ch, ~ch, 2'b11};
			exp_res = i == 0 ? {raw[11:2], 2'b00} : i == 2 ? {raw[11:4], 4'h0} : raw;
			chk("result", exp_res, result);
			chk("channel", ch, channel_select);
			chk("ref_pin", i[0], reference_select_pin);
			chk("comp_on", i[1], comparator_on);
			@(posedge pclk);
			chk("irq_set", 32'h1, irq);
			apb(1'b1, `SACC_IRQ_STAT_ADDR, 32'h0000_0001);
			repeat (2) @(posedge pclk);
			chk("irq_clr", 32'h0, irq);
			apb(1'b0, `SACC_STATUS_ADDR, 32'h0);
			chk("status", {27'h0, i[1], 4'b0100}, rd);
		end
		conclude();
	end
	initial begin
		#400000;
		error_cnt++;
		conclude();
	end
endmodule
bind sacc_ctrl sacc_ctrl_asserts #(.PWRUP_CAL_CYC(PWRUP_CAL_CYC)) asrt_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.busy(busy), .sampling(sampling), .sample_hold(sample_hold),
	.value_ready(value_ready), .result(result),
	.channel_select(channel_select), .irq(irq));
